// File: common/pwr_seq_pkg.sv
// Purpose: constants and carrier types for the power-down and wake sequencer
// Assumes: one 50 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them
`default_nettype none
package pwr_seq_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned POR_DELAY_MS    = 128;
   localparam int unsigned PLL_LOCK_MS     = 1;
   localparam int unsigned XTAL_START_MS   = 150;
   localparam int unsigned POR_CYCLES      = POR_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_MS * (CLK_HZ / 1000);
   localparam int unsigned XTAL_CYCLES     = XTAL_START_MS * (CLK_HZ / 1000);
   localparam int          TIMER_W         = 24;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PWR_PD_BIT       = 1;
   localparam int PWR_SERWAKE_BIT  = 4;
   localparam int PWR_EXT0WAKE_BIT = 5;
   localparam int PLL_LOCK_BIT     = 6;
   localparam int PLL_OSCHALT_BIT  = 7;
   localparam int IE2_INTERVAL_BIT = 2;
   localparam int DIV_W            = 3;

   // ----------------------------------------
   // reset values and vectors
   // ----------------------------------------
   localparam logic [7:0]  PWR_RESET    = 8'h00;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VEC_EXT0     = 16'h0003;
   localparam logic [15:0] VEC_SERIAL   = 16'h003B;
   localparam logic [15:0] VEC_INTERVAL = 16'h0053;

   typedef enum logic [2:0] {
      ST_POR    = 3'b000,
      ST_RUN    = 3'b001,
      ST_SLEEP  = 3'b010,
      ST_XTAL   = 3'b011,
      ST_LOCK   = 3'b100
   } seq_state_t;

   // wake request carried to the core
   typedef struct packed {
      logic        valid;
      logic [15:0] vector;
   } wake_req_t;
endpackage
`default_nettype wire

// File: rtl/power_down_wake_sequencer.sv
// Purpose: power-on delay, power-down entry, wake sources and PLL relock
// Assumes: inputs synchronous to sys_clk; core honours hold and vector jump
// Notes:   the pll lock time is modelled by a counter, not a real loop
`default_nettype none
module power_down_wake_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int unsigned POR_CYC  = POR_CYCLES,
   parameter int unsigned LOCK_CYC = PLL_LOCK_CYCLES,
   parameter int unsigned XTAL_CYC = XTAL_CYCLES
) (
   input  wire logic            sys_clk,
   input  wire logic            sys_rst,
   input  wire logic            clk_en,
   input  wire logic            supply_ok,
   input  wire logic            reset_pin,
   input  wire logic [7:0]      power_control_reg,
   input  wire logic [7:0]      pll_control_in,
   input  wire logic            pd_write_done,
   input  wire logic [7:0]      secondary_irq_enable_reg,
   input  wire logic            irq_global_enable,
   input  wire logic            ext0_irq_enable,
   input  wire logic            serial_irq_enable,
   input  wire logic            interval_irq_pending,
   input  wire logic            serial_irq_pending,
   input  wire logic            ext_irq_zero,
   input  wire logic            core_ale,
   input  wire logic            core_prog_store_strobe,
   input  wire logic [15:0]     return_pc,
   output logic                 core_reset,
   output logic [15:0]          start_vector,
   output wake_req_t            wake_req,
   output logic [15:0]          pushed_pc,
   output logic                 pll_run,
   output logic                 core_clk_en,
   output logic                 osc_run,
   output logic                 periph_en,
   output logic                 interval_wakeup_counter_en,
   output logic                 port_hold,
   output logic                 ale_out,
   output logic                 prog_store_strobe,
   output logic [7:0]           pll_control_reg,
   output logic [DIV_W-1:0]     core_clock_divider,
   output logic                 clk_div_tick,
   output logic                 sleeping
);

   // ----------------------------------------
   // state and timers
   // ----------------------------------------
   seq_state_t          state_reg, state_next;
   logic [TIMER_W-1:0]  timer_reg;
   logic [TIMER_W-1:0]  timer_next;
   logic                osc_halt_in_sleep;
   logic                osc_halted_reg;
   logic                lock_reg;
   logic                serial_wake_enable;
   logic                ext0_wake_enable;
   logic                interval_irq_enable;
   logic                wake_interval;
   logic                wake_serial;
   logic                wake_ext0;
   logic                any_wake;
   logic [DIV_W-1:0]    div_cnt_reg;

   assign osc_halt_in_sleep   = pll_control_in[PLL_OSCHALT_BIT];
   assign serial_wake_enable  = power_control_reg[PWR_SERWAKE_BIT];
   assign ext0_wake_enable    = power_control_reg[PWR_EXT0WAKE_BIT];
   assign interval_irq_enable = secondary_irq_enable_reg[IE2_INTERVAL_BIT];

   // ----------------------------------------
   // wake source qualification
   // ----------------------------------------
   // each source needs its own enable and the global enable; serial and
   // ext0 also need their wake enable bit in the power control register
   // interval wake needs the oscillator alive, else no tick can arrive
   assign wake_interval = interval_irq_pending && interval_irq_enable
                          && irq_global_enable && !osc_halted_reg;
   assign wake_serial   = serial_irq_pending && serial_irq_enable
                          && irq_global_enable && serial_wake_enable;
   assign wake_ext0     = ext_irq_zero && ext0_irq_enable
                          && irq_global_enable && ext0_wake_enable;
   assign any_wake      = (state_reg == ST_SLEEP) &&
                          (wake_interval || wake_serial || wake_ext0);

   // ----------------------------------------
   // sequencer next state
   // ----------------------------------------
   // a dropped supply or the reset pin wins over any wake, so the
   // power-on path is the only way out once either is seen
   // next state; reset pin overrides everything including sleep
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      case (state_reg)
         ST_POR: begin
            // supply below threshold restarts the delay
            if (!supply_ok) begin
               timer_next = '0;
            end else if (timer_reg >= TIMER_W'(POR_CYC - 1)) begin
               state_next = ST_RUN;
               timer_next = '0;
            end else begin
               timer_next = timer_reg + 1'b1;
            end
         end
         ST_RUN: begin
            // waits for the setting instruction to complete
            if (power_control_reg[PWR_PD_BIT] && pd_write_done) begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (any_wake) begin
               timer_next = '0;
               state_next = osc_halted_reg ? ST_XTAL : ST_LOCK;
            end
         end
         ST_XTAL: begin
            if (timer_reg >= TIMER_W'(XTAL_CYC - 1)) begin
               state_next = ST_LOCK;
               timer_next = '0;
            end else begin
               timer_next = timer_reg + 1'b1;
            end
         end
         ST_LOCK: begin
            // code runs unlocked here, so a power-down request is honoured
            if (power_control_reg[PWR_PD_BIT] && pd_write_done) begin
               state_next = ST_SLEEP;
               timer_next = '0;
            end else if (timer_reg >= TIMER_W'(LOCK_CYC - 1)) begin
               state_next = ST_RUN;
               timer_next = '0;
            end else begin
               timer_next = timer_reg + 1'b1;
            end
         end
         default: begin
            state_next = ST_POR;
            timer_next = '0;
         end
      endcase
      if (reset_pin || !supply_ok) begin
         state_next = ST_POR;
         timer_next = '0;
      end
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   // sequencer state; a dropped supply forces the power-on path
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= ST_POR;
         timer_reg <= '0;
      end else if (clk_en) begin
         if (!supply_ok) begin
            state_reg <= ST_POR;
            timer_reg <= '0;
         end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
         end
      end
   end

   // oscillator halt decision frozen at sleep entry
   // sampled once, so a late write to the halt bit cannot change
   // which relock path the wake takes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         osc_halted_reg <= 1'b0;
      end else if (clk_en) begin
         if ((state_reg == ST_RUN || state_reg == ST_LOCK) && state_next == ST_SLEEP) begin
            osc_halted_reg <= osc_halt_in_sleep;
         end else if (state_reg == ST_POR || state_reg == ST_RUN) begin
            osc_halted_reg <= 1'b0;
         end
      end
   end

   // lock flag; clears on every relock path
   // lock rises with the first run cycle; software polling earlier
   // simply reads it low and keeps waiting
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lock_reg <= 1'b0;
      end else if (clk_en) begin
         lock_reg <= (state_next == ST_RUN) && supply_ok;
      end
   end

   // ----------------------------------------
   // wake vector and return address
   // ----------------------------------------
   // priority follows the core's polling order: ext0, serial, interval
   // vector and pushed address hold until the next wake, so the core
   // may read them after the one-cycle valid pulse has gone
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wake_req     <= '0;
         pushed_pc    <= 16'h0000;
         start_vector <= RESET_VECTOR;
      end else if (clk_en) begin
         wake_req.valid <= 1'b0;
         if (state_reg == ST_POR) begin
            start_vector <= RESET_VECTOR;
         end
         if (any_wake && !reset_pin && supply_ok) begin
            wake_req.valid <= 1'b1;
            pushed_pc      <= return_pc;
            if (wake_ext0) begin
               wake_req.vector <= VEC_EXT0;
            end else if (wake_serial) begin
               wake_req.vector <= VEC_SERIAL;
            end else begin
               wake_req.vector <= VEC_INTERVAL;
            end
         end
      end
   end

   // ----------------------------------------
   // clock divider for the low-power run mode
   // ----------------------------------------
   // divide by 2**cd, one tick per divided period
   // divisors beyond the counter width saturate at the widest mask
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         div_cnt_reg  <= '0;
         clk_div_tick <= 1'b0;
      end else if (clk_en) begin
         div_cnt_reg  <= div_cnt_reg + 1'b1;
         clk_div_tick <= (core_clock_divider == '0) ||
                         ((div_cnt_reg & DIV_W'((1 << core_clock_divider) - 1)) == '0);
      end
   end

   // ----------------------------------------
   // outputs toward core, pins and peripherals
   // ----------------------------------------
   // decoded from the next state so pins change on the same edge as
   // the state register, not one cycle behind it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_reset        <= 1'b1;
         pll_run           <= 1'b0;
         core_clk_en       <= 1'b0;
         osc_run           <= 1'b1;
         periph_en         <= 1'b0;
         interval_wakeup_counter_en <= 1'b0;
         port_hold         <= 1'b0;
         ale_out           <= 1'b0;
         prog_store_strobe <= 1'b0;
         sleeping          <= 1'b0;
      end else if (clk_en) begin
         core_reset        <= (state_next == ST_POR) || !supply_ok;
         pll_run           <= (state_next != ST_SLEEP) && (state_next != ST_XTAL);
         core_clk_en       <= (state_next != ST_SLEEP) && (state_next != ST_XTAL);
         osc_run           <= !((state_next == ST_SLEEP) && osc_halt_in_sleep)
                              && !(state_next == ST_XTAL && osc_halted_reg && timer_reg == '0);
         periph_en         <= (state_next == ST_RUN) || (state_next == ST_LOCK);
         interval_wakeup_counter_en <= interval_irq_enable && !(state_next == ST_SLEEP && osc_halt_in_sleep);
         port_hold         <= (state_next == ST_SLEEP);
         ale_out           <= (state_next == ST_SLEEP) ? 1'b0 : core_ale;
         prog_store_strobe <= (state_next == ST_SLEEP) ? 1'b0 : core_prog_store_strobe;
         sleeping          <= (state_next == ST_SLEEP);
      end
   end

   // ----------------------------------------
   // status view
   // ----------------------------------------
   // status view of the pll control register with the live lock bit
   always_comb begin
      pll_control_reg               = pll_control_in;
      pll_control_reg[PLL_LOCK_BIT] = lock_reg;
      core_clock_divider            = pll_control_in[DIV_W-1:0];
   end

endmodule
`default_nettype wire

// File: sim/pwr_seq_partner.sv
// Purpose: core-side wake sources seen by the sequencer
// Assumes: fire pulses come from the bench on falling edges
// Notes:   all pending lines drop once the core takes a wake
`default_nettype none
module pwr_seq_partner
   import pwr_seq_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [2:0] fire,
   input  wire logic       core_reset,
   input  wire wake_req_t  wake_req,
   output wire logic       ext_irq_zero,
   output wire logic       serial_irq_pending,
   output wire logic       interval_irq_pending
);
   logic [2:0] pend_reg = 3'h0;
   // level requests held until serviced, so a late wake still sees them
   always @(negedge sys_clk) begin
      if (core_reset === 1'b1 || wake_req.valid === 1'b1) begin
         pend_reg <= 3'h0;
      end else begin
         pend_reg <= pend_reg | fire;
      end
   end
   assign {interval_irq_pending, serial_irq_pending, ext_irq_zero} = pend_reg;
endmodule
`default_nettype wire

// File: sim/pwr_seq_checker.sv
// Purpose: port assertions for the power-down sequencer
// Assumes: one clock domain, sync reset
// Notes:   lock time counted from the wake pulse
`default_nettype none
module pwr_seq_checker
   import pwr_seq_pkg::*;
#(
   parameter int unsigned POR_CYC  = 8,
   parameter int unsigned LOCK_CYC = 4,
   parameter int unsigned XTAL_CYC = 6
) (
   input wire logic            sys_clk,
   input wire logic            sys_rst,
   input wire logic            supply_ok,
   input wire logic            reset_pin,
   input wire logic [7:0]      power_control_reg,
   input wire logic [7:0]      pll_control_in,
   input wire logic            pd_write_done,
   input wire logic            irq_global_enable,
   input wire logic            ext0_irq_enable,
   input wire logic            ext_irq_zero,
   input wire logic [15:0]     return_pc,
   input wire logic            core_ale,
   input wire logic            core_prog_store_strobe,
   input wire logic            core_reset,
   input wire wake_req_t       wake_req,
   input wire logic [15:0]     pushed_pc,
   input wire logic            pll_run,
   input wire logic            core_clk_en,
   input wire logic            osc_run,
   input wire logic            periph_en,
   input wire logic            port_hold,
   input wire logic            ale_out,
   input wire logic            prog_store_strobe,
   input wire logic [7:0]      pll_control_reg,
   input wire logic [DIV_W-1:0] core_clock_divider,
   input wire logic            clk_div_tick,
   input wire logic            sleeping
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [15:0] since_reg;
   logic        halt_reg;
   // ----------------------------------------
   // wake-to-lock counter
   // ----------------------------------------
   // saturates so a lock after reset never looks like a relock
   always_ff @(posedge sys_clk) begin
      if (sys_rst || reset_pin || !supply_ok) begin
         since_reg <= 16'hFFFF;
      end else if (wake_req.valid) begin
         since_reg <= 16'h0001;
      end else if (since_reg != 16'hFFFF) begin
         since_reg <= since_reg + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (wake_req.valid) begin
         halt_reg <= pll_control_in[7];
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_pd_enter;
      !sleeping && !core_reset && pll_control_reg[6] && power_control_reg[1] && pd_write_done && !reset_pin
         && supply_ok |=> sleeping;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
   property p_sleep_outs;
      sleeping |-> !core_clk_en && !pll_run && !periph_en && !ale_out && !prog_store_strobe && port_hold;
   endproperty
   a_sleep_outs: assert property (p_sleep_outs) else $error("outputs wrong while asleep");
   property p_osc;
      sleeping |-> osc_run == !pll_control_in[7];
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator state wrong");
   property p_ext0;
      sleeping && ext_irq_zero && ext0_irq_enable && irq_global_enable && power_control_reg[5] && !reset_pin
         && supply_ok |=> wake_req.valid && wake_req.vector == VEC_EXT0;
   endproperty
   a_ext0: assert property (p_ext0) else $error("ext0 wake missed");
   property p_serial;
      wake_req.valid && wake_req.vector == VEC_SERIAL |-> $past(power_control_reg[4]);
   endproperty
   a_serial: assert property (p_serial) else $error("serial wake not enabled");
   property p_pushed;
      wake_req.valid |-> pushed_pc == $past(return_pc);
   endproperty
   a_pushed: assert property (p_pushed) else $error("return address wrong");
   property p_origin;
      wake_req.valid |-> $past(sleeping);
   endproperty
   a_origin: assert property (p_origin) else $error("wake outside power-down");
   property p_reset_wake;
      sleeping && reset_pin |=> !sleeping && !wake_req.valid;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset pin did not end power-down");
   property p_lock_time;
      $rose(pll_control_reg[6]) && since_reg != 16'hFFFF |-> since_reg == (halt_reg ? XTAL_CYC + LOCK_CYC : LOCK_CYC);
   endproperty
   a_lock_time: assert property (p_lock_time) else $error("lock time wrong");
   property p_div;
      core_clock_divider == 3'h1 && $stable(core_clock_divider) && clk_div_tick |=> !clk_div_tick;
   endproperty
   a_div: assert property (p_div) else $error("divider tick wrong");
   property p_strobes;
      !sleeping && !$past(sys_rst) |-> ale_out == $past(core_ale)
         && prog_store_strobe == $past(core_prog_store_strobe);
   endproperty
   a_strobes: assert property (p_strobes) else $error("strobe pass-through wrong");
endmodule
`default_nettype wire

// File: sim/power_down_wake_sequencer_tb.sv
// Purpose: self-checking bench for the power-down sequencer
// Assumes: shortened counts 8, 4, 6 cycles
// Notes:   wake pulses are compared against a queue of notes
`default_nettype none
module power_down_wake_sequencer_tb
   import pwr_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned P = 8;
   logic sys_clk, sys_rst, clk_en, supply_ok, reset_pin, pd_write_done, irq_global_enable, ext0_irq_enable;
   logic serial_irq_enable, interval_irq_pending, serial_irq_pending, ext_irq_zero, core_ale, core_prog_store_strobe;
   logic core_reset, pll_run, core_clk_en, osc_run, periph_en, interval_wakeup_counter_en, port_hold, ale_out;
   logic prog_store_strobe, clk_div_tick, sleeping;
   logic [7:0]  power_control_reg, pll_control_in, secondary_irq_enable_reg, pll_control_reg;
   logic [15:0] return_pc, start_vector, pushed_pc;
   logic [2:0]  fire, core_clock_divider;
   wake_req_t   wake_req;
   int          bad_count, n_checks, n;
   logic [31:0] exp_q[$];
   power_down_wake_sequencer #(.POR_CYC(8), .LOCK_CYC(4), .XTAL_CYC(6)) power_down_wake_sequencer_inst (.*);
   pwr_seq_partner pwr_seq_partner_inst (.*);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // bounded wait for a running, locked core
   task automatic wait_run();
      for (int i = 0; i < 200; i++) begin
         @(negedge sys_clk);
         if (core_reset === 1'b0 && pll_control_reg[6] === 1'b1) return;
      end
      bad_count++;
      end_of_test();
   endtask
   task automatic por_check();
      n = 0;
      while (core_reset !== 1'b0 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk("por_len", n >= P && n <= P + 2, 1);
      chk("start_vector", start_vector, RESET_VECTOR);
   endtask
   task automatic enter_pd(input logic halt);
      wait_run();
      pll_control_in = {halt, 7'h00};
      return_pc = 16'($urandom);
      power_control_reg[1] = 1'b1;
      pd_write_done = 1'b1;
      @(negedge sys_clk);
      {power_control_reg[1], pd_write_done} = 2'b00;
      @(negedge sys_clk);
      chk("sleeping", sleeping, 1);
      chk("sleep_outs", {core_clk_en, pll_run, periph_en, ale_out, prog_store_strobe, port_hold}, 1);
      chk("osc_run", osc_run, !halt);
      chk("wake_cnt_en", interval_wakeup_counter_en, !halt);
   endtask
   // fixed window: a refused source must leave the part asleep
   task automatic wake(input logic [2:0] src, input logic [15:0] vec, input logic hit);
      if (hit) exp_q.push_back({vec, return_pc});
      fire <= src;
      @(negedge sys_clk);
      fire <= 3'h0;
      repeat (4) @(negedge sys_clk);
      chk("asleep", sleeping, !hit);
   endtask
   // ----------------------------------------
   // clock, strobes, monitor
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) {core_ale, core_prog_store_strobe} <= 2'($urandom);
   always @(negedge sys_clk) begin
      if (wake_req.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("stray_wake", 1, 0);
         end else begin
            chk("vector_pc", {wake_req.vector, pushed_pc}, exp_q.pop_front());
         end
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(61646));
      {sys_rst, clk_en, supply_ok, reset_pin, pd_write_done} = 5'h1C;
      {irq_global_enable, ext0_irq_enable, serial_irq_enable, fire} = 6'h38;
      {power_control_reg, pll_control_in, secondary_irq_enable_reg} = 24'h300004;
      return_pc = 16'h0000;
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'b0;
      por_check();
      $display("test power-on done");
      // each source alone, then all at once where ext0 wins
      enter_pd(1'b0); wake(3'b001, VEC_EXT0, 1'b1);
      enter_pd(1'b0); wake(3'b010, VEC_SERIAL, 1'b1);
      enter_pd(1'b0); wake(3'b100, VEC_INTERVAL, 1'b1);
      enter_pd(1'b0); wake(3'b111, VEC_EXT0, 1'b1);
      $display("test wake sources done");
      power_control_reg = 8'h00;
      enter_pd(1'b0); wake(3'b011, VEC_EXT0, 1'b0);
      reset_pin = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("reset_wake", sleeping, 0);
      reset_pin = 1'b0;
      power_control_reg = 8'h30;
      $display("test refusal and reset pin done");
      enter_pd(1'b1); wake(3'b100, VEC_INTERVAL, 1'b0); wake(3'b001, VEC_EXT0, 1'b1);
      $display("test oscillator halt done");
      wait_run();
      for (int cd = 0; cd < 3; cd++) begin
         pll_control_in = 8'(cd);
         repeat (4) @(negedge sys_clk);
         n = 0;
         repeat (8) begin
            @(negedge sys_clk);
            n += int'(clk_div_tick === 1'b1);
         end
         chk("div_ticks", n, 8 >> cd);
      end
      $display("test divider done");
      enter_pd(1'b0);
      supply_ok = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("supply_reset", core_reset, 1);
      supply_ok = 1'b1;
      por_check();
      chk("queue_empty", exp_q.size(), 0);
      $display("test power cycle done");
      end_of_test();
   end
endmodule
bind power_down_wake_sequencer pwr_seq_checker #(.POR_CYC(POR_CYC), .LOCK_CYC(LOCK_CYC), .XTAL_CYC(XTAL_CYC))
   pwr_seq_checker_inst (.*);
`default_nettype wire
